// File: bench/rotate_subtract_swap_exec_test.sv
`timescale 1ns/10ps
`default_nettype none
module rotate_subtract_swap_exec_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic instrValid = 1'b0;
  logic [13:0] instrWord = 14'h0000;
  logic wakePin = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic instrReady, instrDone, sleepMode, oscStop;
  logic [7:0] regRdData, accOut;
  logic [4:0] statusOut;
  int n_errors = 0;
  int compares = 0;
  rssx_exec dut_u (.clk, .srst, .instrValid, .instrWord, .instrReady, .instrDone, .wakePin, .sleepMode,
    .oscStop, .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .accOut, .statusOut);
  // clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdData, e);
  endtask : rd
  task automatic ins(input logic [13:0] w, input logic ed);
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= w;
    @(posedge clk);
    instrValid <= 1'b0;
    #1 chk(instrDone, ed);
  endtask : ins
  // expected status and result
  function automatic logic [12:0] model(input logic [5:0] op, input logic [7:0] f, w, input logic [4:0] st);
    logic [7:0] r;
    r = f - w;
    case (op)
      6'h0D: return {st[4:1], f[7], f[6:0], st[0]};
      6'h0C: return {st[4:1], f[0], st[0], f[7:1]};
      6'h0E: return {st, f[3:0], f[7:4]};
      default: return {st[4:3], r == 8'h00, f[3:0] >= w[3:0], f >= w, r};
    endcase
  endfunction : model
  // one operation on file register 7F
  task automatic run(input logic [5:0] op, input logic d, input logic [7:0] f, w, input logic [4:0] st);
    logic [12:0] e;
    e = model(op, f, w, st);
    wr(8'h7F, f);
    wr(8'h80, w);
    wr(8'h81, {3'h0, st});
    ins(op == 6'h1D ? {op, f} : {op, d, 7'h7F}, 1'b1);
    chk(statusOut, e[12:8]);
    chk(accOut, d ? w : e[7:0]);
    rd(8'h7F, d ? e[7:0] : f);
  endtask : run
  task automatic end_of_test();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
  // tests
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h18);
    rd(8'h00, 8'h00);
    run(6'h0D, 1'b0, 8'hE6, 8'h00, 5'h18);
    run(6'h0D, 1'b1, 8'h80, 8'h00, 5'h19);
    run(6'h0C, 1'b1, 8'h01, 8'h00, 5'h18);
    run(6'h0C, 1'b0, 8'h80, 8'h00, 5'h19);
    run(6'h1D, 1'b0, 8'h15, 8'h10, 5'h18);
    run(6'h1D, 1'b0, 8'h10, 8'h10, 5'h18);
    run(6'h1D, 1'b0, 8'h05, 8'h10, 5'h1F);
    run(6'h02, 1'b1, 8'h03, 8'h02, 5'h18);
    run(6'h02, 1'b1, 8'h02, 8'h02, 5'h18);
    run(6'h02, 1'b0, 8'h01, 8'h02, 5'h18);
    run(6'h0E, 1'b0, 8'hA5, 8'h00, 5'h1D);
    run(6'h0E, 1'b1, 8'h3C, 8'h44, 5'h1A);
    ins(14'h0003, 1'b1);
    chk({sleepMode, oscStop, instrReady, statusOut[4:3]}, 5'b11010);
    ins(14'h1D00, 1'b0);
    chk(accOut, 8'h44);
    rd(8'h82, 8'h01);
    @(posedge clk);
    wakePin <= 1'b1;
    repeat (4) @(posedge clk);
    wakePin <= 1'b0;
    #1 chk(sleepMode, 1'b0);
    rd(8'h82, 8'h00);
    wr(8'hC0, 8'h5A);
    rd(8'hC0, 8'h00);
    ins(14'h3FFF, 1'b1);
    chk(accOut, 8'h44);
    // software file write beside an instruction file write to another register
    @(posedge clk);
    instrValid <= 1'b1;
    instrWord <= 14'h0EFF;
    regWrite <= 1'b1;
    regAddr <= 8'h10;
    regWrData <= 8'h77;
    @(posedge clk);
    instrValid <= 1'b0;
    regWrite <= 1'b0;
    rd(8'h10, 8'h77);
    rd(8'h7F, 8'h3C);
    end_of_test();
  end
endmodule : rotate_subtract_swap_exec_test
`default_nettype wire

// File: bench/rssx_exec_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rssx_exec_monitor (
  // watched ports
  input wire logic clk,
  input wire logic srst,
  input wire logic instrValid,
  input wire logic [13:0] instrWord,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic instrDone,
  input wire logic sleepMode,
  input wire logic oscStop,
  input wire logic [7:0] accOut,
  input wire logic [4:0] statusOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // accepted word and its class
  wire logic go = instrValid && !sleepMode;
  wire logic [5:0] opc = instrWord[13:8];
  // legal software writes that move acc or status beside an instruction
  wire logic accWr = regWrite && regAddr == 8'h80;
  wire logic stWr = regWrite && regAddr == 8'h81;
  property p_done; go |=> instrDone; endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_lsub; go && opc == 6'h1D |=> accOut == $past(instrWord[7:0]) - $past(accOut); endproperty
  a_lsub: assert property (p_lsub) else $error("bad literal difference");
  property p_flag; go && opc == 6'h1D |=> statusOut[0] == ($past(instrWord[7:0]) >= $past(accOut))
    && statusOut[2] == (accOut == 8'h00); endproperty
  a_flag: assert property (p_flag) else $error("bad borrow or zero");
  property p_sleep; go && instrWord == 14'h0003 |=> sleepMode && oscStop && statusOut[4:3] == 2'b10; endproperty
  a_sleep: assert property (p_sleep) else $error("no power-down");
  property p_refuse; sleepMode && !accWr |=> !instrDone && $stable(accOut); endproperty
  a_refuse: assert property (p_refuse) else $error("word taken asleep");
  property p_nibx; go && opc == 6'h0E && !stWr |=> $stable(statusOut); endproperty
  a_nibx: assert property (p_nibx) else $error("flags moved");
  property p_dest; go && !accWr && instrWord[7] && opc inside {6'h0D, 6'h0C, 6'h0E, 6'h02} |=> $stable(accOut);
  endproperty
  a_dest: assert property (p_dest) else $error("acc written");
  property p_rot; go && !stWr && (opc == 6'h0D || opc == 6'h0C) |=> statusOut[4:1] == $past(statusOut[4:1]);
  endproperty
  a_rot: assert property (p_rot) else $error("rotate moved flags");
  // main scenarios
  c_sleep: cover property (go && instrWord == 14'h0003);
  c_borrow: cover property (go && opc == 6'h1D ##1 !statusOut[0]);
  c_wake: cover property ($fell(sleepMode));
endmodule : rssx_exec_monitor
bind rssx_exec rssx_exec_monitor mon_u (.clk, .srst, .instrValid, .instrWord, .regWrite, .regAddr, .instrDone,
  .sleepMode, .oscStop, .accOut, .statusOut);
`default_nettype wire

// File: rtl/rssx_alu.sv
`timescale 1ns/10ps
`default_nettype none
module rssx_alu (
  // operands and results
  rssx_alu_if.alu bus
);
  logic [7:0] minuend;
  logic [8:0] diff;
  logic [4:0] lowDiff;

  // combinational result and flag generation
  always_comb begin
    minuend = (bus.op == rssx_pkg::OP_LITSUB) ? bus.literal : bus.fileVal;
    diff = {1'b0, minuend} + {1'b0, ~bus.accVal} + 9'h001;
    lowDiff = {1'b0, minuend[3:0]} + {1'b0, ~bus.accVal[3:0]} + 5'h01;
    bus.result = bus.fileVal;
    bus.carryOut = bus.carryIn;
    bus.halfOut = lowDiff[4];
    bus.zeroOut = 1'b0;
    unique case (bus.op)
      rssx_pkg::OP_ROTL: begin
        bus.result = {bus.fileVal[6:0], bus.carryIn};
        bus.carryOut = bus.fileVal[7];
      end
      rssx_pkg::OP_ROTR: begin
        bus.result = {bus.carryIn, bus.fileVal[7:1]};
        bus.carryOut = bus.fileVal[0];
      end
      rssx_pkg::OP_LITSUB, rssx_pkg::OP_FILESUB: begin
        bus.result = diff[7:0];
        bus.carryOut = diff[8];
        bus.zeroOut = (diff[7:0] == 8'h00);
      end
      rssx_pkg::OP_NIBX: begin
        bus.result = {bus.fileVal[3:0], bus.fileVal[7:4]};
      end
      rssx_pkg::OP_NONE, rssx_pkg::OP_SLEEP: begin
        bus.result = bus.fileVal;
      end
      default: begin
        bus.result = bus.fileVal;
      end
    endcase
  end
endmodule : rssx_alu
`default_nettype wire

// File: rtl/rssx_alu_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rssx_alu_if;
  rssx_pkg::rssx_op_type op;
  logic [7:0] fileVal;
  logic [7:0] accVal;
  logic [7:0] literal;
  logic carryIn;
  logic [7:0] result;
  logic carryOut;
  logic halfOut;
  logic zeroOut;

  // core side drives operands
  modport core (
    output op, fileVal, accVal, literal, carryIn,
    input result, carryOut, halfOut, zeroOut
  );
  // datapath side computes
  modport alu (
    input op, fileVal, accVal, literal, carryIn,
    output result, carryOut, halfOut, zeroOut
  );
endinterface : rssx_alu_if
`default_nettype wire

// File: rtl/rssx_exec.sv
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Rotate-left-carry shifts the file register left, old carry into bit 0, old bit 7 into carry, one cycle.
// - With the destination bit 0 the result goes to the accumulator, with 1 back to the file register.
// - Rotate-right-carry moves bit 0 into carry and the old carry into bit 7.
// - The power-down word enters sleep, stops the oscillator and updates the expiry and sleep flags.
// - Literal-minus-acc puts literal minus accumulator into the accumulator and sets carry, half and zero.
// - File-minus-acc subtracts the accumulator from the file register, steered by the destination bit.
// - Nibble exchange swaps the two halves of the file register, steered, flags untouched.
module rssx_exec (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // instruction stream
  input wire logic instrValid,
  input wire logic [13:0] instrWord,
  output logic instrReady,
  output logic instrDone,
  // wake pin from outside
  input wire logic wakePin,
  // power state
  output logic sleepMode,
  output logic oscStop,
  // software register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // architectural state view
  output logic [7:0] accOut,
  output logic [4:0] statusOut
);
  rssx_alu_if aluBus ();

  rssx_alu u_alu (
    .bus(aluBus.alu)
  );

  // opcode decode, shared by operand selection and execute logic
  function automatic rssx_pkg::rssx_op_type decodeOp(input logic [13:0] w);
    logic [5:0] opc;
    opc = w[rssx_pkg::OPC_HI:rssx_pkg::OPC_LO];
    if (w == rssx_pkg::SLEEP_WORD) begin
      decodeOp = rssx_pkg::OP_SLEEP;
    end else if (opc == rssx_pkg::ROTL_PAT) begin
      decodeOp = rssx_pkg::OP_ROTL;
    end else if (opc == rssx_pkg::ROTR_PAT) begin
      decodeOp = rssx_pkg::OP_ROTR;
    end else if (opc == rssx_pkg::FSUB_PAT) begin
      decodeOp = rssx_pkg::OP_FILESUB;
    end else if (opc == rssx_pkg::NIBX_PAT) begin
      decodeOp = rssx_pkg::OP_NIBX;
    end else if (opc == rssx_pkg::LSUB_PAT) begin
      decodeOp = rssx_pkg::OP_LITSUB;
    end else begin
      decodeOp = rssx_pkg::OP_NONE;
    end
  endfunction : decodeOp

  // file register storage
  logic [7:0] fileMem [rssx_pkg::FILE_DEPTH];

  // wake pin synchroniser
  logic wakeMeta_ff;
  logic wakeSync_ff;

  // architectural state
  logic [7:0] acc_ff;
  logic [7:0] nxt_acc;
  logic [4:0] status_ff;
  logic [4:0] nxt_status;
  logic sleep_ff;
  logic nxt_sleep;
  logic done_ff;
  logic nxt_done;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic fileWe;
  logic [6:0] fileWa;
  logic [7:0] fileWd;
  logic swFileWe;

  // decoded current instruction
  rssx_pkg::rssx_op_type curOp;
  logic [6:0] fAddr;
  logic toFile;
  logic accepted;

  // operand selection toward the datapath
  always_comb begin
    curOp = decodeOp(instrWord);
    fAddr = instrWord[rssx_pkg::FADDR_HI:0];
    toFile = instrWord[rssx_pkg::DEST_BIT];
    accepted = instrValid && !sleep_ff;
    aluBus.op = accepted ? curOp : rssx_pkg::OP_NONE;
    aluBus.fileVal = fileMem[fAddr];
    aluBus.accVal = acc_ff;
    aluBus.literal = instrWord[7:0];
    aluBus.carryIn = status_ff[rssx_pkg::ST_CARRY];
  end

  // next state of accumulator, flags, power state and file write
  always_comb begin
    nxt_acc = acc_ff;
    nxt_status = status_ff;
    nxt_sleep = sleep_ff;
    nxt_done = 1'b0;
    fileWe = 1'b0;
    fileWa = fAddr;
    fileWd = aluBus.result;
    swFileWe = 1'b0;
    // software writes first, the instruction overrides a clash
    if (regWrite) begin
      if (!regAddr[7]) begin
        swFileWe = 1'b1; // own port, lost only when an instruction writes the same address
      end else if (regAddr == rssx_pkg::ADDR_ACC) begin
        nxt_acc = regWrData;
      end else if (regAddr == rssx_pkg::ADDR_STATUS) begin
        nxt_status = regWrData[4:0];
      end
    end
    // wake pin ends power-down
    if (sleep_ff && wakeSync_ff) begin
      nxt_sleep = 1'b0;
    end
    if (accepted) begin
      nxt_done = 1'b1;
      unique case (curOp)
        rssx_pkg::OP_ROTL, rssx_pkg::OP_ROTR: begin
          nxt_status[rssx_pkg::ST_CARRY] = aluBus.carryOut;
        end
        rssx_pkg::OP_LITSUB, rssx_pkg::OP_FILESUB: begin
          nxt_status[rssx_pkg::ST_CARRY] = aluBus.carryOut;
          nxt_status[rssx_pkg::ST_HALF] = aluBus.halfOut;
          nxt_status[rssx_pkg::ST_ZERO] = aluBus.zeroOut;
        end
        rssx_pkg::OP_SLEEP: begin
          nxt_sleep = 1'b1;
          nxt_status[rssx_pkg::ST_EXPIRY] = 1'b1;
          nxt_status[rssx_pkg::ST_SLEPT] = 1'b0;
        end
        rssx_pkg::OP_NIBX, rssx_pkg::OP_NONE: begin
          nxt_status = nxt_status;
        end
      endcase
      // destination steering
      if (curOp == rssx_pkg::OP_LITSUB) begin
        nxt_acc = aluBus.result;
      end else if (curOp == rssx_pkg::OP_ROTL || curOp == rssx_pkg::OP_ROTR ||
                   curOp == rssx_pkg::OP_FILESUB || curOp == rssx_pkg::OP_NIBX) begin
        if (toFile) begin
          fileWe = 1'b1;
          fileWa = fAddr;
          fileWd = aluBus.result;
        end else begin
          nxt_acc = aluBus.result;
        end
      end
    end
  end

  // software read path, data stands one cycle later
  always_comb begin
    nxt_rdData = 8'h00;
    if (regRead) begin
      if (!regAddr[7]) begin
        nxt_rdData = fileMem[regAddr[6:0]];
      end else if (regAddr == rssx_pkg::ADDR_ACC) begin
        nxt_rdData = acc_ff;
      end else if (regAddr == rssx_pkg::ADDR_STATUS) begin
        nxt_rdData = {3'h0, status_ff};
      end else if (regAddr == rssx_pkg::ADDR_CTRL) begin
        nxt_rdData = {7'h00, sleep_ff};
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    wakeMeta_ff <= wakePin;
    wakeSync_ff <= wakeMeta_ff;
    if (srst) begin
      acc_ff <= rssx_pkg::ACC_RST;
      status_ff <= rssx_pkg::STATUS_RST;
      sleep_ff <= 1'b0;
      done_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      acc_ff <= nxt_acc;
      status_ff <= nxt_status;
      sleep_ff <= nxt_sleep;
      done_ff <= nxt_done;
      rdData_ff <= nxt_rdData;
    end
  end

  // file register array, cleared by reset
  always_ff @(posedge clk) begin
    for (int i = 0; i < rssx_pkg::FILE_DEPTH; i++) begin
      if (srst) begin
        fileMem[i] <= rssx_pkg::FILE_RST;
      end else if (fileWe && fileWa == 7'(i)) begin
        fileMem[i] <= fileWd;
      end else if (swFileWe && regAddr[6:0] == 7'(i)) begin
        fileMem[i] <= regWrData;
      end
    end
  end

  // outputs
  assign instrReady = !sleep_ff;
  assign instrDone = done_ff;
  assign sleepMode = sleep_ff;
  assign oscStop = sleep_ff;
  assign regRdData = rdData_ff;
  assign accOut = acc_ff;
  assign statusOut = status_ff;
endmodule : rssx_exec
`default_nettype wire

// File: rtl/rssx_pkg.sv
package rssx_pkg;
  // instruction classes handled by this block
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROTL,
    OP_ROTR,
    OP_LITSUB,
    OP_FILESUB,
    OP_NIBX,
    OP_SLEEP
  } rssx_op_type;

  // opcode match patterns, upper bits only except the whole power-down word
  localparam logic [5:0] ROTL_PAT = 6'h0D;
  localparam logic [5:0] ROTR_PAT = 6'h0C;
  localparam logic [5:0] FSUB_PAT = 6'h02;
  localparam logic [5:0] NIBX_PAT = 6'h0E;
  localparam logic [5:0] LSUB_PAT = 6'h1D;
  localparam logic [13:0] SLEEP_WORD = 14'h0003;

  // instruction word field positions
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int FADDR_HI = 6;

  // status bit positions
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEPT = 3;
  localparam int ST_EXPIRY = 4;

  // software port map
  localparam logic [7:0] ADDR_ACC = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_CTRL = 8'h82;

  // values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam int FILE_DEPTH = 128;
endpackage : rssx_pkg
